// ==== design/hpmr_router.sv ====
// hub port merge router: merges port streams and routes them by mode and config
// How it works
// - three routing configurations, used only while network is in manual mode
// - merge-all config routes exactly like automatic mode
// - merge-nine merges audio of ports 1-9, sends it on port 10 only
// - merge-nine forwards the port 10 audio to ports 1-9
// - merge-nine merges side-channel data from all ten ports
// - merge-eight merges audio of ports 1-8, sends on port 8 and pair 9/10
// - merge-eight forwards audio of ports 9/10 to ports 1-7
// - merge-eight treats ports 9 and 10 as a redundant backup pair
// - merge-eight merges side-channel data of all ports
// - automatic mode merges all ten streams and sends on all ports
// - button press cycles stored config; one always selected and indicated
// - entering manual mode applies the stored configuration
`timescale 1ns/1ps
`default_nettype none
module hpmr_router
    import hpmr_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // network mode and front panel
    input  wire logic                 manualMode,
    input  wire logic                 cfgButton,
    output var  logic [2:0]           cfgLed,
    output var  logic                 manualActive,
    // received streams, one word per port per slot
    input  wire hpmr_word_s [NUM_PORTS-1:0] rxWord,
    input  wire logic [NUM_PORTS-1:0] rxValid,
    // transmit side after the output fifo, fill-side ready and pair status
    output var  hpmr_word_s [NUM_PORTS-1:0] txWord,
    output var  logic                 txValid,
    input  wire logic                 txReady,
    output var  logic                 rxReady,
    output var  logic                 pairPrimaryIs10
);
    // pin inputs pass three flops; change counts when stages two and three agree
    logic [2:0] btnSync_q, btnSync_d, modeSync_q, modeSync_d;
    logic       btnLevel_q, btnLevel_d, modeLevel_q, modeLevel_d;
    logic       btnPress;
    hpmr_cfg_e  storedCfg_q, storedCfg_d, activeCfg_q, activeCfg_d;
    logic       manual_q, manual_d;
    logic       primary10_q, primary10_d;

    always_comb
    begin
        btnSync_d   = {btnSync_q[1:0], cfgButton};
        modeSync_d  = {modeSync_q[1:0], manualMode};
        btnLevel_d  = (btnSync_q[1] == btnSync_q[2]) ? btnSync_q[2] : btnLevel_q;
        modeLevel_d = (modeSync_q[1] == modeSync_q[2]) ? modeSync_q[2] : modeLevel_q;
        btnPress    = btnLevel_d && !btnLevel_q;
        storedCfg_d = storedCfg_q;
        if (btnPress)
        begin
            unique case (storedCfg_q)
                CFG_MERGE_ALL:   storedCfg_d = CFG_MERGE_NINE;
                CFG_MERGE_NINE:  storedCfg_d = CFG_MERGE_EIGHT;
                default:         storedCfg_d = CFG_MERGE_ALL;
            endcase
        end
        manual_d    = modeLevel_q;
        // stored config followed live while manual, so presses take effect too
        activeCfg_d = modeLevel_q ? storedCfg_q : CFG_MERGE_ALL;
        // keep primary while it is valid; fall to the other one only when the other is valid and the primary is not
        primary10_d = primary10_q;
        if (primary10_q && !rxValid[PORT_10_IDX] && rxValid[PORT_9_IDX])
            primary10_d = 1'b0;
        else if (!primary10_q && !rxValid[PORT_9_IDX] && rxValid[PORT_10_IDX])
            primary10_d = 1'b1;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            btnSync_q   <= 3'h0;
            modeSync_q  <= 3'h0;
            btnLevel_q  <= 1'b0;
            modeLevel_q <= 1'b0;
            storedCfg_q <= CFG_MERGE_ALL;
            activeCfg_q <= CFG_MERGE_ALL;
            manual_q    <= 1'b0;
            primary10_q <= 1'b1;
        end
        else
        begin
            btnSync_q   <= btnSync_d;
            modeSync_q  <= modeSync_d;
            btnLevel_q  <= btnLevel_d;
            modeLevel_q <= modeLevel_d;
            storedCfg_q <= storedCfg_d;
            activeCfg_q <= activeCfg_d;
            manual_q    <= manual_d;
            primary10_q <= primary10_d;
        end
    end

    // merge: audio summed over a port mask, side-channel bits or-ed over all
    function automatic logic [DATA_W-1:0] mergeAudio(input hpmr_word_s [NUM_PORTS-1:0] w,
                                                     input logic [NUM_PORTS-1:0] m);
        logic [DATA_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < NUM_PORTS; i++)
            if (m[i])
                acc = DATA_W'(acc + w[i].audio);
        return acc;
    endfunction

    logic [NUM_PORTS-1:0] vMask;
    logic [DATA_W-1:0]    sumAll, sumNine, sumEight, pairAudio;
    logic [SIDE_W-1:0]    sideAll;
    hpmr_word_s [NUM_PORTS-1:0] slot;

    always_comb
    begin
        vMask    = rxValid;
        sumAll   = mergeAudio(rxWord, vMask & MASK_ALL);
        sumNine  = mergeAudio(rxWord, vMask & MASK_NINE);
        sumEight = mergeAudio(rxWord, vMask & MASK_EIGHT);
        pairAudio = primary10_q ? rxWord[PORT_10_IDX].audio : rxWord[PORT_9_IDX].audio;
        sideAll  = '0;
        for (int i = 0; i < NUM_PORTS; i++)
            if (rxValid[i])
                sideAll = sideAll | rxWord[i].sideChannelControlData;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            slot[p].sideChannelControlData = sideAll;
            slot[p].audio                  = sumAll;
            unique case (activeCfg_q)
                CFG_MERGE_NINE:
                    slot[p].audio = (p == PORT_10_IDX) ? sumNine
                                                       : rxWord[PORT_10_IDX].audio;
                CFG_MERGE_EIGHT:
                    slot[p].audio = (p >= PORT_8_IDX) ? sumEight : pairAudio;
                default:
                    slot[p].audio = sumAll;
            endcase
        end
    end

    // output fifo; a stall on txReady reaches rxReady
    logic                   fifoOutValid;
    logic [NUM_PORTS*WORD_W-1:0] fifoOut;
    logic                   fifoInReady;

    hpmr_fifo #(.WIDTH(NUM_PORTS*WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .nrst     (nrst),
        .inValid  (|rxValid),
        .inReady  (fifoInReady),
        .inData   (slot),
        .outValid (fifoOutValid),
        .outReady (txReady || !txValid),
        .outData  (fifoOut)
    );

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            txWord          <= '0;
            txValid         <= 1'b0;
            rxReady         <= 1'b0;
            cfgLed          <= 3'h1;
            manualActive    <= 1'b0;
            pairPrimaryIs10 <= 1'b1;
        end
        else
        begin
            if (txReady || !txValid)
            begin
                txValid <= fifoOutValid;
                txWord  <= fifoOut;
            end
            rxReady         <= fifoInReady;
            cfgLed          <= 3'(1 << storedCfg_q);
            manualActive    <= manual_q;
            pairPrimaryIs10 <= primary10_q;
        end
    end

    one_led_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $onehot(cfgLed)) else $error("config led not one-hot");
    auto_cfg_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !modeLevel_q |=> activeCfg_q == CFG_MERGE_ALL) else $error("auto not merge all");
    apply_cfg_a: assert property (@(posedge core_clk) disable iff (!nrst)
        modeLevel_q |=> activeCfg_q == $past(storedCfg_q)) else $error("stored cfg not applied");
    btn_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
        btnPress && storedCfg_q == CFG_MERGE_ALL |=> storedCfg_q == CFG_MERGE_NINE)
        else $error("button did not advance");
    // checked against the wider sums, so a wrong port mask shows up here
    nine_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
        activeCfg_q == CFG_MERGE_NINE |-> slot[PORT_10_IDX].audio == DATA_W'(sumAll
            - (rxValid[PORT_10_IDX] ? rxWord[PORT_10_IDX].audio : 16'h0000)))
        else $error("port 10 not merge nine");
    nine_fwd_a: assert property (@(posedge core_clk) disable iff (!nrst)
        activeCfg_q == CFG_MERGE_NINE |-> slot[0].audio == rxWord[PORT_10_IDX].audio)
        else $error("port 10 not forwarded");
    eight_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
        activeCfg_q == CFG_MERGE_EIGHT |-> slot[PORT_8_IDX].audio == DATA_W'(sumNine
            - (rxValid[PORT_9_IDX] ? rxWord[PORT_9_IDX].audio : 16'h0000))
            && slot[PORT_9_IDX].audio == slot[PORT_8_IDX].audio
            && slot[PORT_10_IDX].audio == slot[PORT_8_IDX].audio)
        else $error("ports 8-10 not merge eight");
    eight_fwd_a: assert property (@(posedge core_clk) disable iff (!nrst)
        activeCfg_q == CFG_MERGE_EIGHT
            |-> slot[0].audio == rxWord[primary10_q ? PORT_10_IDX : PORT_9_IDX].audio)
        else $error("pair not forwarded");
    side_all_a: assert property (@(posedge core_clk) disable iff (!nrst)
        rxValid == '0 |-> slot[3].sideChannelControlData == '0)
        else $error("side data without a source");
    fail_over_a: assert property (@(posedge core_clk) disable iff (!nrst)
        primary10_q && !rxValid[PORT_10_IDX] && rxValid[PORT_9_IDX] |=> !primary10_q)
        else $error("no failover");
    fail_back_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !primary10_q && !rxValid[PORT_9_IDX] && rxValid[PORT_10_IDX] |=> primary10_q)
        else $error("no failover to port 10");
    btn_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
        btnPress && storedCfg_q == CFG_MERGE_EIGHT |=> storedCfg_q == CFG_MERGE_ALL)
        else $error("button did not wrap");
    btn_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !btnPress |=> $stable(storedCfg_q)) else $error("config moved without press");
    // a stalled sink must keep seeing the same slot until it takes it
    tx_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        txValid && !txReady |=> txValid && $stable(txWord)) else $error("tx slot not held");
    rx_refuse_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !fifoInReady |=> !rxReady) else $error("full fifo not shown");

    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port_chk
        side_each_a: assert property (@(posedge core_clk) disable iff (!nrst)
            rxValid[g] |-> (slot[g].sideChannelControlData & rxWord[g].sideChannelControlData)
                == rxWord[g].sideChannelControlData)
            else $error("side data of a port lost");
        all_same_a: assert property (@(posedge core_clk) disable iff (!nrst)
            activeCfg_q == CFG_MERGE_ALL |-> slot[g].audio == slot[0].audio)
            else $error("merge all ports differ");
        nine_each_a: assert property (@(posedge core_clk) disable iff (!nrst)
            activeCfg_q == CFG_MERGE_NINE && MASK_NINE[g]
                |-> slot[g].audio == rxWord[PORT_10_IDX].audio)
            else $error("port not fed from port 10");
        seven_each_a: assert property (@(posedge core_clk) disable iff (!nrst)
            activeCfg_q == CFG_MERGE_EIGHT && MASK_SEVEN[g]
                |-> slot[g].audio == slot[0].audio)
            else $error("ports 1-7 differ");
    end
endmodule
`default_nettype wire

// ==== design/hpmr_pkg.sv ====
// package for the hub port merge router: types and constants
package hpmr_pkg;
    localparam int NUM_PORTS    = 10;
    localparam int DATA_W       = 16;
    localparam int SIDE_W       = 8;
    localparam int FIFO_DEPTH   = 8;
    localparam int PORT_8_IDX   = 7;
    localparam int PORT_9_IDX   = 8;
    localparam int PORT_10_IDX  = 9;
    localparam logic [9:0] MASK_ALL   = 10'h3FF;
    localparam logic [9:0] MASK_NINE  = 10'h1FF;
    localparam logic [9:0] MASK_EIGHT = 10'h0FF;
    localparam logic [9:0] MASK_SEVEN = 10'h07F;

    typedef enum logic [1:0]
    {
        CFG_MERGE_ALL   = 2'h0,
        CFG_MERGE_NINE  = 2'h1,
        CFG_MERGE_EIGHT = 2'h2
    } hpmr_cfg_e;

    // one time slot of a stream: audio word and side-channel control bits
    typedef struct packed
    {
        logic [DATA_W-1:0] audio;
        logic [SIDE_W-1:0] sideChannelControlData;
    } hpmr_word_s;

    localparam int WORD_W = DATA_W + SIDE_W;
endpackage

// ==== design/hpmr_fifo.sv ====
// parameterised valid/ready fifo built from flip-flops
`timescale 1ns/1ps
`default_nettype none
module hpmr_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // fill side
    input  wire logic             inValid,
    output var  logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output var  logic             outValid,
    input  wire logic             outReady,
    output var  logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0]      count_q, count_d;
    logic             push, pop;

    always_comb
    begin
        push     = inValid && (count_q != AW'(0) + (AW+1)'(DEPTH));
        pop      = (count_q != '0) && outReady;
        wrPtr_d  = push ? AW'((wrPtr_q == AW'(DEPTH-1)) ? 0 : wrPtr_q + 1'b1) : wrPtr_q;
        rdPtr_d  = pop  ? AW'((rdPtr_q == AW'(DEPTH-1)) ? 0 : rdPtr_q + 1'b1) : rdPtr_q;
        count_d  = (AW+1)'(count_q + push - pop);
        inReady  = (count_q != (AW+1)'(DEPTH));
        outValid = (count_q != '0);
        outData  = mem_q[rdPtr_q];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // storage holds no control state, so no reset
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[wrPtr_q] <= inData;
    end
endmodule
`default_nettype wire

// ==== tb/hpmr_sink_model.sv ====
// far-side node model: accepts transmitted slots, may stall
`timescale 1ns/1ps
`default_nettype none
module hpmr_sink_model
    import hpmr_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // hub transmit side
    input  wire hpmr_word_s [NUM_PORTS-1:0] txWord,
    input  wire logic                       txValid,
    output var  logic                       txReady,
    // bench control and capture
    input  wire logic                       stall,
    output var  hpmr_word_s [NUM_PORTS-1:0] gotWord,
    output var  int                         gotCount
);
    assign txReady = ~stall;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            gotCount <= 0;
        else if (txValid && txReady)
        begin
            gotWord  <= txWord;
            gotCount <= gotCount + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/hub_port_merge_router_tb_top.sv ====
// testbench for the hub port merge router
`timescale 1ns/1ps
`default_nettype none
module hub_port_merge_router_tb_top
    import hpmr_pkg::*;
;
    logic core_clk, nrst, manualMode, cfgButton, manualActive, stall;
    logic txValid, txReady, rxReady, pairPrimaryIs10;
    logic [2:0] cfgLed;
    logic [NUM_PORTS-1:0] rxValid;
    hpmr_word_s [NUM_PORTS-1:0] rxWord, txWord, gotWord, expW;
    int gotCount, n_fail, n_compared, cycles, n0;

    hpmr_router u_hpmr_router (.core_clk(core_clk), .nrst(nrst), .manualMode(manualMode),
        .cfgButton(cfgButton), .cfgLed(cfgLed), .manualActive(manualActive),
        .rxWord(rxWord), .rxValid(rxValid), .txWord(txWord), .txValid(txValid),
        .txReady(txReady), .rxReady(rxReady), .pairPrimaryIs10(pairPrimaryIs10));
    hpmr_sink_model u_hpmr_sink_model (.core_clk(core_clk), .nrst(nrst), .txWord(txWord),
        .txValid(txValid), .txReady(txReady), .stall(stall), .gotWord(gotWord),
        .gotCount(gotCount));

    initial
    begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            $display("mismatch timeout at %0t", $time);
            tally_and_finish();
        end
    end

    task automatic chk_w(input hpmr_word_s [NUM_PORTS-1:0] got,
                         input hpmr_word_s [NUM_PORTS-1:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // expected slot from the applied words under config c
    function automatic hpmr_word_s [NUM_PORTS-1:0] exp_slot(input hpmr_cfg_e c, input logic p10);
        logic [DATA_W-1:0] sA, sN, sE;
        logic [SIDE_W-1:0] sd;
        hpmr_word_s [NUM_PORTS-1:0] e;
        {sA, sN, sE, sd} = '0;
        for (int i = 0; i < NUM_PORTS; i++)
            if (rxValid[i])
            begin
                sA += rxWord[i].audio;
                if (i < 9) sN += rxWord[i].audio;
                if (i < 8) sE += rxWord[i].audio;
                sd |= rxWord[i].sideChannelControlData;
            end
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            e[i].sideChannelControlData = sd;
            case (c)
                CFG_MERGE_NINE: e[i].audio = (i == PORT_10_IDX) ? sN : rxWord[PORT_10_IDX].audio;
                CFG_MERGE_EIGHT: e[i].audio = (i >= PORT_8_IDX) ? sE
                    : rxWord[p10 ? PORT_10_IDX : PORT_9_IDX].audio;
                default: e[i].audio = sA;
            endcase
        end
        return e;
    endfunction

    // distinct audio per port, one side bit per port
    task automatic load(input logic [9:0] v, input logic [15:0] b);
        for (int i = 0; i < NUM_PORTS; i++)
            rxWord[i] = {b + 16'(i) * 16'h0111, 8'(1 << (i % 8))};
        rxValid = v;
    endtask

    // one slot in, wait for it at the sink; expectation left in expW
    task automatic xfer(input hpmr_cfg_e c, input logic p10,
                        input logic [9:0] v, input logic [15:0] b);
        load(v, b);
        expW = exp_slot(c, p10);
        n0 = gotCount;
        step();
        rxValid = '0;
        rxWord = ~rxWord;
        for (int k = 0; k < 50 && gotCount == n0; k++) step();
        chk_v(gotCount, n0 + 1);
    endtask

    task automatic press();
        cfgButton = 1;
        step(6);
        cfgButton = 0;
        step(6);
    endtask

    task automatic t_auto();
        chk_v(cfgLed, 3'h1);
        chk_v(pairPrimaryIs10, 1);
        xfer(CFG_MERGE_ALL, 1, 10'h3FF, 16'h1234);
        chk_w(gotWord, expW);
        xfer(CFG_MERGE_ALL, 1, 10'h2A5, 16'hF00D);
        chk_w(gotWord, expW);
        press();
        chk_v(cfgLed, 3'h2);
        xfer(CFG_MERGE_ALL, 1, 10'h3FF, 16'h0A0B);
        chk_w(gotWord, expW);
    endtask

    // stall the sink until the fifo refuses, then drain it
    task automatic t_fifo();
        stall = 1;
        load(10'h3FF, 16'h5555);
        expW = exp_slot(CFG_MERGE_ALL, 1);
        n0 = gotCount;
        step(20);
        chk_v(gotCount, n0);
        chk_v(rxReady, 0);
        chk_v(txValid, 1);
        rxValid = '0;
        stall = 0;
        step(20);
        // eight in the fifo plus one in the output register
        chk_v(gotCount - n0, FIFO_DEPTH + 1);
        chk_w(gotWord, expW);
        chk_v(rxReady, 1);
    endtask

    task automatic t_manual();
        manualMode = 1;
        step(8);
        chk_v(manualActive, 1);
        xfer(CFG_MERGE_NINE, 1, 10'h3FF, 16'h2468);
        chk_w(gotWord, expW);
        press();
        chk_v(cfgLed, 3'h4);
        xfer(CFG_MERGE_EIGHT, 1, 10'h2FF, 16'h1357);
        chk_w(gotWord, expW);
        press();
        chk_v(cfgLed, 3'h1);
        xfer(CFG_MERGE_ALL, 1, 10'h3FF, 16'h7777);
        chk_w(gotWord, expW);
    endtask

    task automatic t_pair();
        press();
        press();
        xfer(CFG_MERGE_EIGHT, 1, 10'h1FF, 16'h3333);
        chk_v(pairPrimaryIs10, 0);
        xfer(CFG_MERGE_EIGHT, 0, 10'h3FF, 16'h4321);
        chk_w(gotWord, expW);
        chk_v(pairPrimaryIs10, 0);
        xfer(CFG_MERGE_EIGHT, 0, 10'h2FF, 16'h5A5A);
        chk_w(gotWord, expW);
        chk_v(pairPrimaryIs10, 1);
    endtask

    // back to automatic, then a reset in mid-run
    task automatic t_reset();
        manualMode = 0;
        step(8);
        chk_v(manualActive, 0);
        xfer(CFG_MERGE_ALL, 1, 10'h1FF, 16'h6B6B);
        chk_w(gotWord, expW);
        chk_v(pairPrimaryIs10, 0);
        nrst = 0;
        step();
        chk_v(cfgLed, 3'h1);
        chk_v({txValid, rxReady, manualActive, pairPrimaryIs10}, 4'h1);
        nrst = 1;
        step(2);
        chk_v(rxReady, 1);
        chk_v(cfgLed, 3'h1);
    endtask

    initial
    begin
        {nrst, manualMode, cfgButton, stall, rxValid, rxWord} = '0;
        {n_fail, n_compared, cycles} = '0;
        step(3);
        nrst = 1;
        step(3);
        t_auto();
        t_fifo();
        t_manual();
        t_pair();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
